//--- hw/fll_dev_end.sv
// Fuse/lock controller: control register, fuse and lock read-out,
// lock protection decode and flash programming timing.
// Assumes fuse/lock/flash arrays and the EEPROM busy flag on CLK.
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - EEPROM write blocks all self-programming
// - EEPROM write blocks fuse/lock read-out
// - Software checks EEPROM busy before control write
// - Pointer 0x0001 plus enables reads lock byte
// - Enables clear after read or three cycles
// - Enables clear: load reads program memory
// - Pointer 0x0000 reads fuse low byte
// - Pointer 0x0003 reads fuse high byte
// - Programmed bits read zero, unprogrammed one
// - Erase/write/lock timed 3.7 to 4.5 ms, CPU halted
// - Reset does not abort flash write
// - Lock bits return to one only by erase
// - Lock byte: bit1 second, bit0 first, rest one
// - Mode 1 leaves every lock feature off
// - Mode 2 blocks external programming, fuses, debug
// - Mode 3 also blocks external verify read-back
// - Debug fuse keeps memory readable over debug
// - Programmer sets fuses before lock bits
module fll_dev_end
   import fll_pkg::*;
(
   // Clock and resets
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        PWR_RST_B,
   // CPU link
   fll_link_if.dev          L,
   // EEPROM and fuse/lock arrays
   input  wire logic        EE_WR_BUSY,
   input  wire logic [7:0]  FUSE_LO,
   input  wire logic [7:0]  FUSE_HI,
   input  wire logic [1:0]  LOCK_NV,
   // Flash array
   output var  logic [15:0] FLASH_RD_ADDR,
   input  wire logic [7:0]  FLASH_RD_DATA,
   output var  logic        FL_ERASE_STB,
   output var  logic        FL_WRITE_STB,
   output var  logic [4:0]  FL_PAGE,
   output var  logic        PB_LOAD_STB,
   output var  logic        PB_CLEAR_STB,
   output var  logic [3:0]  PB_WORD,
   output var  logic [15:0] PB_DATA,
   output var  logic        LOCK_PGM_STB,
   output var  logic [1:0]  LOCK_PGM_VAL,
   // Protection for programming and debug interfaces
   output var  logic        EXT_PGM_EN,
   output var  logic        EXT_VERIFY_EN,
   output var  logic        FUSE_WR_EN,
   output var  logic        DBG_EN,
   output var  logic        DBG_FLASH_RD_EN
);
   logic [4:0] csr_q;
   logic [2:0] win_q;
   logic       legal;
   logic       csr_ok;
   logic       rd_fuse;
   logic       spm_go;
   logic       long_op;
   logic       tmr_busy;
   logic       tmr_done;
   logic       start_q;
   logic [7:0] sel_byte;

   // Only the five documented codes have any effect
   assign legal = (L.csr_wdata == OP_CTB) || (L.csr_wdata == OP_RFL) ||
                  (L.csr_wdata == OP_WRT) || (L.csr_wdata == OP_ERS) ||
                  (L.csr_wdata == OP_LD);
   assign csr_ok  = L.csr_wr && legal && !EE_WR_BUSY && !tmr_busy;
   assign rd_fuse = L.load_program_memory_instr && csr_q[CSR_RFL] && csr_q[CSR_EN] &&
                    (win_q != 3'h0) && !EE_WR_BUSY;
   assign spm_go  = L.store_program_memory_instr && csr_q[CSR_EN] && (win_q != 3'h0) &&
                    !tmr_busy && !EE_WR_BUSY;
   assign long_op = spm_go && (csr_q[CSR_ERS] || csr_q[CSR_WRT] || csr_q[CSR_RFL]);

   // Link answers
   assign L.csr_rdata    = {3'h0, csr_q};
   // Launch cycle counts as busy, so no transfer slips in before the timer
   assign L.halt         = tmr_busy || start_q;
   assign FLASH_RD_ADDR  = L.z;

   // Control register and its enable window
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         csr_q <= 5'h00;
         win_q <= 3'h0;
      end else if (csr_ok) begin
         csr_q <= L.csr_wdata;
         win_q <= L.csr_wdata[CSR_RFL] ? RFL_WIN : SPM_WIN;
      end else if (tmr_busy || start_q || tmr_done) begin
         // Done pulse lands after busy drops, so it is caught here too
         win_q <= 3'h0;                      // Enable stays up while flash is busy
         if (tmr_done) begin
            csr_q <= 5'h00;
         end
      end else if (long_op) begin
         win_q <= 3'h0;
      end else if (rd_fuse || spm_go) begin
         csr_q <= 5'h00;
         win_q <= 3'h0;
      end else if (win_q == 3'h1) begin
         csr_q <= 5'h00;                     // Window ran out unused
         win_q <= 3'h0;
      end else if (win_q != 3'h0) begin
         win_q <= win_q - 3'h1;
      end
   end

   // Read-out source: raw array bits, programmed reads zero
   always_comb begin
      sel_byte = 8'hff;
      if (L.z == Z_LOCK) begin
         sel_byte = {LOCK_PAD, LOCK_NV};
      end else if (L.z == Z_FUSE_LO) begin
         sel_byte = FUSE_LO;
      end else if (L.z == Z_FUSE_HI) begin
         sel_byte = FUSE_HI;
      end
   end

   // Load answer, one cycle after the load
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         L.rd_valid <= 1'b0;
         L.rd_data  <= 8'h00;
      end else begin
         L.rd_valid <= L.load_program_memory_instr;
         if (rd_fuse) begin
            L.rd_data <= sel_byte;
         end else if (L.load_program_memory_instr) begin
            L.rd_data <= FLASH_RD_DATA;
         end
      end
   end

   // Array strobes; lock write can only clear bits
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         FL_ERASE_STB <= 1'b0;
         FL_WRITE_STB <= 1'b0;
         PB_LOAD_STB  <= 1'b0;
         PB_CLEAR_STB <= 1'b0;
         LOCK_PGM_STB <= 1'b0;
         start_q      <= 1'b0;
      end else begin
         FL_ERASE_STB <= spm_go && csr_q[CSR_ERS];
         FL_WRITE_STB <= spm_go && csr_q[CSR_WRT];
         PB_LOAD_STB  <= spm_go && (csr_q == OP_LD);
         PB_CLEAR_STB <= spm_go && csr_q[CSR_CTB];
         LOCK_PGM_STB <= spm_go && csr_q[CSR_RFL];
         start_q      <= long_op;
      end
   end

   // Strobe payloads
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         FL_PAGE      <= 5'h00;
         PB_WORD      <= 4'h0;
         PB_DATA      <= 16'h0000;
         LOCK_PGM_VAL <= LOCK_M1;
      end else if (spm_go) begin
         FL_PAGE      <= L.z[Z_PAGE_LSB +: 5];
         PB_WORD      <= L.z[Z_WORD_LSB +: 4];
         PB_DATA      <= L.r_data;
         LOCK_PGM_VAL <= LOCK_NV & L.r_data[1:0];
      end
   end

   // Write timing survives system reset
   fll_prog_timer u_timer (
      .clk       (CLK),
      .pwr_rst_b (PWR_RST_B),
      .start     (start_q),
      .busy      (tmr_busy),
      .done      (tmr_done)
   );

   // Protection decode from the lock bits
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         EXT_PGM_EN    <= 1'b0;
         EXT_VERIFY_EN <= 1'b0;
         FUSE_WR_EN    <= 1'b0;
         DBG_EN        <= 1'b0;
      end else begin
         unique case (LOCK_NV)
            LOCK_M1: begin
               EXT_PGM_EN    <= 1'b1;
               EXT_VERIFY_EN <= 1'b1;
               FUSE_WR_EN    <= 1'b1;
               DBG_EN        <= !FUSE_HI[DBG_FUSE_BIT];
            end
            LOCK_M2: begin
               EXT_PGM_EN    <= 1'b0;
               EXT_VERIFY_EN <= 1'b1;
               FUSE_WR_EN    <= 1'b0;
               DBG_EN        <= 1'b0;
            end
            // Mode 3, and the unlisted code, lock everything
            default: begin
               EXT_PGM_EN    <= 1'b0;
               EXT_VERIFY_EN <= 1'b0;
               FUSE_WR_EN    <= 1'b0;
               DBG_EN        <= 1'b0;
            end
         endcase
      end
   end

   // Debug read path ignores the lock bits; clear the fuse to secure
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         DBG_FLASH_RD_EN <= 1'b0;
      end else begin
         DBG_FLASH_RD_EN <= !FUSE_HI[DBG_FUSE_BIT];
      end
   end
endmodule : fll_dev_end
`default_nettype wire

//--- hw/fll_pkg.sv
// Constants shared by both ends of the fuse/lock read-out link.
// Assumes a single 250 MHz system clock.
package fll_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int TICK_NS       = 1000;      // Time base standing in for the RC oscillator
   localparam int PROG_MIN_NS   = 3_700_000; // Shortest flash/lock write
   localparam int PROG_MAX_NS   = 4_500_000; // Longest flash/lock write
   localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
   localparam int PROG_TICKS    = (PROG_MIN_NS + TICK_NS - 1) / TICK_NS;
   // Control register bits
   localparam int CSR_EN   = 0;
   localparam int CSR_ERS  = 1;
   localparam int CSR_WRT  = 2;
   localparam int CSR_RFL  = 3;
   localparam int CSR_CTB  = 4;
   localparam logic [4:0] OP_CTB = 5'h11;
   localparam logic [4:0] OP_RFL = 5'h09;
   localparam logic [4:0] OP_WRT = 5'h05;
   localparam logic [4:0] OP_ERS = 5'h03;
   localparam logic [4:0] OP_LD  = 5'h01;
   localparam logic [2:0] RFL_WIN = 3'h3;
   localparam logic [2:0] SPM_WIN = 3'h4;
   // Read-out addresses and layout
   localparam logic [15:0] Z_FUSE_LO = 16'h0000;
   localparam logic [15:0] Z_LOCK    = 16'h0001;
   localparam logic [15:0] Z_FUSE_HI = 16'h0003;
   localparam logic [5:0]  LOCK_PAD  = 6'h3f;
   localparam int DBG_FUSE_BIT = 3;
   localparam int Z_WORD_LSB = 1;
   localparam int Z_PAGE_LSB = 5;
   localparam logic [1:0] LOCK_M1 = 2'h3;
   localparam logic [1:0] LOCK_M2 = 2'h2;
   localparam logic [1:0] LOCK_M3 = 2'h0;
   // Host register map (byte offsets) and fields
   localparam logic [7:0] REG_CMD  = 8'h00;
   localparam logic [7:0] REG_Z    = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0c;
   localparam int CMD_WR_BIT  = 8;
   localparam int CMD_LPM_BIT = 9;
   localparam int CMD_SPM_BIT = 10;
   localparam int STAT_HALT   = 8;
   localparam int STAT_CSR    = 16;
endpackage : fll_pkg

//--- hw/fll_link_if.sv
// Link between the CPU end and the fuse/lock controller end.
// Both ends share CLK; every signal is driven from a flop or a state decode.
`timescale 1ns/100ps
`default_nettype none
interface fll_link_if;
   logic        csr_wr;    // One-cycle write of the control register
   logic [4:0]  csr_wdata;
   logic [7:0]  csr_rdata;
   logic [15:0] z;         // Address pointer
   logic [15:0] r_data;    // Store data word
   logic        load_program_memory_instr;       // One-cycle load instruction
   logic        store_program_memory_instr;       // One-cycle store instruction
   logic        rd_valid;  // One-cycle answer to lpm
   logic [7:0]  rd_data;
   logic        halt;      // CPU held while flash is busy
   modport dev (input csr_wr, csr_wdata, z, r_data, load_program_memory_instr, store_program_memory_instr,
                output csr_rdata, rd_valid, rd_data, halt);
   modport cpu (output csr_wr, csr_wdata, z, r_data, load_program_memory_instr, store_program_memory_instr,
                input csr_rdata, rd_valid, rd_data, halt);
endinterface : fll_link_if
`default_nettype wire

//--- hw/fll_prog_timer.sv
// Flash/lock programming timer, paced by a microsecond enable.
// Reset only by power-on reset so a system reset cannot cut a write short.
`timescale 1ns/100ps
`default_nettype none
module fll_prog_timer
   import fll_pkg::*;
(
   // Clock and power-on reset
   input  wire logic clk,
   input  wire logic pwr_rst_b,
   // Control
   input  wire logic start,
   output var  logic busy,
   output var  logic done
);
   logic [7:0]  tick_q;
   logic [11:0] cnt_q;
   logic        tick;

   assign tick = (tick_q == 8'(TICK_CYC - 1));
   assign busy = (cnt_q != 12'h000);

   // Oscillator stand-in: one enable pulse per microsecond while a write runs
   always_ff @(posedge clk or negedge pwr_rst_b) begin
      if (!pwr_rst_b) begin
         tick_q <= 8'h00;
      end else if (!busy || tick) begin
         tick_q <= 8'h00;
      end else begin
         tick_q <= tick_q + 8'h01;
      end
   end

   // Ticks left in the write
   always_ff @(posedge clk or negedge pwr_rst_b) begin
      if (!pwr_rst_b) begin
         cnt_q <= 12'h000;
      end else if (start && !busy) begin
         cnt_q <= 12'(PROG_TICKS);
      end else if (busy && tick) begin
         cnt_q <= cnt_q - 12'h001;
      end
   end

   // Completion pulse
   always_ff @(posedge clk or negedge pwr_rst_b) begin
      if (!pwr_rst_b) begin
         done <= 1'b0;
      end else begin
         done <= busy && tick && (cnt_q == 12'h001);
      end
   end
endmodule : fll_prog_timer
`default_nettype wire

//--- hw/fll_cpu_end.sv
// CPU end: AHB-Lite register slave that issues control writes, loads and
// stores on the link. Assumes a single-slave bus on CLK, word transfers.
`timescale 1ns/100ps
`default_nettype none
module fll_cpu_end
   import fll_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output var  logic [31:0] HRDATA,
   output var  logic        HREADYOUT,
   output var  logic        HRESP,
   // Link to the controller
   fll_link_if.cpu          L
);
   typedef enum logic [1:0] {S_IDLE, S_CSR, S_OP, S_WAIT} fll_seq_e;
   fll_seq_e    st_q;
   logic        act_q;
   logic        wr_q;
   logic [7:0]  adr_q;
   logic [10:0] cmd_q;
   logic [15:0] z_q;
   logic [15:0] dat_q;
   logic [7:0]  rd_q;
   logic        take;
   logic        wr_cmd;
   logic [7:0]  rsel;
   logic [31:0] rmux;

   assign take      = HSEL && HTRANS[1] && HREADY;
   assign wr_cmd    = act_q && wr_q && HREADYOUT && (adr_q == REG_CMD);
   assign HREADYOUT = (st_q == S_IDLE) && !L.halt;   // CPU stalls while flash busy
   assign HRESP     = 1'b0;
   assign L.csr_wr    = (st_q == S_CSR);
   assign L.csr_wdata = cmd_q[4:0];
   assign L.load_program_memory_instr       = (st_q == S_OP) && cmd_q[CMD_LPM_BIT];
   assign L.store_program_memory_instr       = (st_q == S_OP) && cmd_q[CMD_SPM_BIT];
   assign L.z         = z_q;
   assign L.r_data    = dat_q;

   // Address phase capture
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         act_q <= 1'b0;
         wr_q  <= 1'b0;
         adr_q <= 8'h00;
      end else if (HREADY) begin
         act_q <= take;
         wr_q  <= HWRITE;
         adr_q <= HADDR[7:0];
      end
   end

   // Register writes in the data phase
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cmd_q <= 11'h000;
         z_q   <= 16'h0000;
         dat_q <= 16'h0000;
      end else if (act_q && wr_q && HREADYOUT) begin
         if (adr_q == REG_CMD) cmd_q <= HWDATA[10:0];
         if (adr_q == REG_Z)   z_q   <= HWDATA[15:0];
         if (adr_q == REG_DATA) dat_q <= HWDATA[15:0];
      end
   end

   // Sequencer: control write, then load/store on the very next cycle
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st_q <= S_IDLE;
      end else begin
         unique case (st_q)
            S_IDLE: begin
               if (wr_cmd && HWDATA[CMD_WR_BIT]) begin
                  st_q <= S_CSR;
               end else if (wr_cmd && (HWDATA[CMD_LPM_BIT] || HWDATA[CMD_SPM_BIT])) begin
                  st_q <= S_OP;
               end
            end
            S_CSR: begin
               // Load lands inside the three-cycle window
               st_q <= (cmd_q[CMD_LPM_BIT] || cmd_q[CMD_SPM_BIT]) ? S_OP : S_IDLE;
            end
            S_OP: begin
               st_q <= cmd_q[CMD_LPM_BIT] ? S_WAIT : S_IDLE;
            end
            S_WAIT: begin
               if (L.rd_valid) st_q <= S_IDLE;
            end
         endcase
      end
   end

   // Load result
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rd_q <= 8'h00;
      end else if (L.rd_valid) begin
         rd_q <= L.rd_data;
      end
   end

   // Read mux; refreshed every cycle so a stalled read sees final state
   assign rsel = take ? HADDR[7:0] : adr_q;
   always_comb begin
      rmux = 32'h0000_0000;
      unique case (rsel)
         REG_CMD:  rmux = {21'h000000, cmd_q};
         REG_Z:    rmux = {16'h0000, z_q};
         REG_DATA: rmux = {16'h0000, dat_q};
         REG_STAT: rmux = {8'h00, L.csr_rdata, 7'h00, L.halt, rd_q};
         default:  rmux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         HRDATA <= 32'h0000_0000;
      end else begin
         HRDATA <= rmux;
      end
   end
endmodule : fll_cpu_end
`default_nettype wire

//--- hw/fll_unused_placeholder_none.sv
// Intentionally minimal: no logic.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- verification/fll_link_monitor.sv
// Concurrent checks on the link between the CPU end and the controller end.
// Assumes one clock; only PWR_RST_B stops the programming timer.
`timescale 1ns/100ps
`default_nettype none
module fll_link_monitor
   import fll_pkg::*;
(
   // Clock and resets
   input  wire logic        CLK,
   input  wire logic        RST_B,
   input  wire logic        PWR_RST_B,
   // Array side levels
   input  wire logic        EE_WR_BUSY,
   input  wire logic [7:0]  FUSE_LO,
   input  wire logic [7:0]  FUSE_HI,
   input  wire logic [1:0]  LOCK_NV,
   // Link signals
   input  wire logic        csr_wr,
   input  wire logic [7:0]  csr_rdata,
   input  wire logic [15:0] z,
   input  wire logic        load_program_memory_instr,
   input  wire logic        store_program_memory_instr,
   input  wire logic        rd_valid,
   input  wire logic [7:0]  rd_data,
   input  wire logic        halt
);
   // Divider starts from zero with each write, yet allow one tick less as margin
   localparam int HALT_MIN = PROG_TICKS * TICK_CYC - TICK_CYC;
   logic [19:0] hcnt_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   // Halt length; reset only by power-on reset, like the timer
   always_ff @(posedge CLK or negedge PWR_RST_B) begin
      if (!PWR_RST_B)
         hcnt_q <= '0;
      else
         hcnt_q <= halt ? hcnt_q + 20'h1 : 20'h0;
   end

   // Load issued while the read enables are armed
   sequence s_rfl_load(logic [15:0] zv);
      csr_rdata[4:0] == OP_RFL && load_program_memory_instr && z == zv && !EE_WR_BUSY;
   endsequence

   AST_LOCK_RD: assert property (
      s_rfl_load(Z_LOCK) |=> rd_data == {LOCK_PAD, $past(LOCK_NV)})
      else $error("lock byte read wrong");
   AST_FUSE_LO: assert property (
      s_rfl_load(Z_FUSE_LO) |=> rd_data == $past(FUSE_LO))
      else $error("fuse low read wrong");
   AST_FUSE_HI: assert property (
      s_rfl_load(Z_FUSE_HI) |=> rd_data == $past(FUSE_HI))
      else $error("fuse high read wrong");
   AST_LPM_ANSWER: assert property (
      load_program_memory_instr |=> rd_valid)
      else $error("load not answered");
   // A lock write keeps the enables up, but only once the CPU is halted
   AST_RFL_TIMEOUT: assert property (
      $rose(csr_rdata[CSR_RFL]) |-> ##[1:3] (!csr_rdata[CSR_RFL] || halt))
      else $error("read enables stayed armed");
   AST_RD_CLEARS: assert property (
      csr_rdata[CSR_RFL] && load_program_memory_instr |=> csr_rdata[4:0] == 5'h00)
      else $error("read enables not cleared");
   AST_EE_REFUSE: assert property (
      csr_wr && EE_WR_BUSY && csr_rdata == 8'h00 |=> csr_rdata == 8'h00)
      else $error("control written while eeprom busy");
   AST_HALT_ON_SPM: assert property (
      csr_rdata[4:0] == OP_ERS && store_program_memory_instr |-> ##[1:3] halt)
      else $error("erase did not halt");
   AST_HALT_MIN: assert property (
      @(posedge CLK) disable iff (!PWR_RST_B) $fell(halt) |-> hcnt_q >= HALT_MIN)
      else $error("halt ended too early");
endmodule // fll_link_monitor
`default_nettype wire

//--- verification/tb_fuse_lock_readout_protection.sv
// Bench: CPU end and controller end joined by the link, driven over AHB-Lite.
// Assumes the fll design files and the link monitor compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_fuse_lock_readout_protection
   import fll_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_b, pwr_rst_b, ee_busy, hsel, hwrite;
   logic [31:0] haddr, hwdata, rd_q;
   logic [1:0]  htrans, lock_nv;
   logic [2:0]  hsize;
   logic [7:0]  fuse_lo, fuse_hi;
   wire  [31:0] hrdata;
   wire  [15:0] flash_rd_addr;
   wire  [7:0]  flash_rd_data;
   wire  [3:0]  prot;
   wire  [1:0]  lock_pgm_val;
   wire  [4:0]  fl_page;
   wire         hready, hreadyout, fl_erase_stb, lock_pgm_stb, dbg_rd_en;
   int          err_total = 0;
   int          comparisons = 0;
   int          erase_cnt = 0;
   int          lock_cnt = 0;
   logic [1:0]  modes [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
   logic [3:0]  prot_exp [4] = '{4'hf, 4'h4, 4'h0, 4'h0};

   // 250 MHz clock
   always #2 clk = ~clk;
   assign hready = hreadyout;
   // Flash data tied to the address so a wrong source shows
   assign flash_rd_data = flash_rd_addr[7:0] ^ 8'hc3;
   // Count array strobes
   always @(posedge clk) begin
      if (fl_erase_stb === 1'b1) erase_cnt++;
      if (lock_pgm_stb === 1'b1) lock_cnt++;
   end

   fll_link_if fll_link_if_inst ();
   fll_cpu_end fll_cpu_end_inst (.CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(), .L(fll_link_if_inst));
   fll_dev_end fll_dev_end_inst (.CLK(clk), .RST_B(rst_b), .PWR_RST_B(pwr_rst_b),
      .L(fll_link_if_inst), .EE_WR_BUSY(ee_busy), .FUSE_LO(fuse_lo), .FUSE_HI(fuse_hi),
      .LOCK_NV(lock_nv), .FLASH_RD_ADDR(flash_rd_addr), .FLASH_RD_DATA(flash_rd_data),
      .FL_ERASE_STB(fl_erase_stb), .FL_WRITE_STB(), .FL_PAGE(fl_page), .PB_LOAD_STB(),
      .PB_CLEAR_STB(), .PB_WORD(), .PB_DATA(), .LOCK_PGM_STB(lock_pgm_stb),
      .LOCK_PGM_VAL(lock_pgm_val), .EXT_PGM_EN(prot[3]), .EXT_VERIFY_EN(prot[2]),
      .FUSE_WR_EN(prot[1]), .DBG_EN(prot[0]), .DBG_FLASH_RD_EN(dbg_rd_en));
   fll_link_monitor fll_link_monitor_inst (.CLK(clk), .RST_B(rst_b), .PWR_RST_B(pwr_rst_b),
      .EE_WR_BUSY(ee_busy), .FUSE_LO(fuse_lo), .FUSE_HI(fuse_hi), .LOCK_NV(lock_nv),
      .csr_wr(fll_link_if_inst.csr_wr), .csr_rdata(fll_link_if_inst.csr_rdata),
      .z(fll_link_if_inst.z), .load_program_memory_instr(fll_link_if_inst.load_program_memory_instr), .store_program_memory_instr(fll_link_if_inst.store_program_memory_instr),
      .rd_valid(fll_link_if_inst.rd_valid), .rd_data(fll_link_if_inst.rd_data),
      .halt(fll_link_if_inst.halt));

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait for hready sampled high at a rising edge
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 2000);
      if (hready !== 1'b1) chk("hready wait", 32'h1, 32'h0);
   endtask

   // Single word transfer: address phase, then data phase
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd_q = hrdata;
   endtask

   // Pointer, command, then status holding the loaded byte
   task automatic load(input logic [15:0] zv, input logic [31:0] cmd);
      ahb(1'b1, REG_Z, {16'h0, zv});
      ahb(1'b1, REG_CMD, cmd);
      ahb(1'b0, REG_STAT, 32'h0);
   endtask

   // A running write must outlive system reset; power-on reset ends it
   task automatic reset_during_halt();
      chk("halt after store", 32'h1, {31'h0, fll_link_if_inst.halt});
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (50) @(posedge clk);
      chk("halt across reset", 32'h1, {31'h0, fll_link_if_inst.halt});
      rst_b <= 1'b0;
      pwr_rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      pwr_rst_b <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   initial begin
      {rst_b, pwr_rst_b, ee_busy, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      fuse_lo = 8'h6a;
      fuse_hi = 8'he5;
      lock_nv = 2'h2;                              // Fuses set before locks
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      pwr_rst_b <= 1'b1;
      load(Z_LOCK, 32'h309);
      chk("lock byte", 32'hfe, {24'h0, rd_q[7:0]});
      chk("csr after read", 32'h0, {24'h0, rd_q[23:16]});
      load(Z_FUSE_LO, 32'h309);
      chk("fuse low", 32'h6a, {24'h0, rd_q[7:0]});
      load(Z_FUSE_HI, 32'h309);
      chk("fuse high", 32'he5, {24'h0, rd_q[7:0]});
      load(Z_LOCK, 32'h200);
      chk("plain load", 32'hc2, {24'h0, rd_q[7:0]});
      // Armed enables left to lapse
      ahb(1'b1, REG_CMD, 32'h109);
      repeat (6) @(posedge clk);
      load(Z_LOCK, 32'h200);
      chk("load after lapse", 32'hc2, {24'h0, rd_q[7:0]});
      ee_busy <= 1'b1;
      load(Z_FUSE_LO, 32'h309);
      chk("fuse read eeprom busy", 32'hc3, {24'h0, rd_q[7:0]});
      ahb(1'b1, REG_CMD, 32'h503);
      repeat (8) @(posedge clk);
      chk("erase eeprom busy", 32'h0, {erase_cnt[30:0], fll_link_if_inst.halt});
      // Busy seen clear before any further control write
      ee_busy <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         lock_nv <= modes[i];
         repeat (3) @(posedge clk);
         chk("protection", {28'h0, prot_exp[i]}, {28'h0, prot});
      end
      chk("debug read fuse set", 32'h1, {31'h0, dbg_rd_en});
      fuse_hi <= 8'hed;
      lock_nv <= 2'h2;
      repeat (3) @(posedge clk);
      chk("debug read fuse clear", 32'h0, {31'h0, dbg_rd_en});
      // Lock write asking to set a programmed bit back to one
      ahb(1'b1, REG_DATA, 32'h3);
      ahb(1'b1, REG_CMD, 32'h509);
      repeat (4) @(posedge clk);
      chk("lock strobes", 32'h1, lock_cnt);
      chk("lock value", 32'h2, {30'h0, lock_pgm_val});
      reset_during_halt();
      // Page 0x0d sits in pointer bits 9..5
      ahb(1'b1, REG_Z, 32'h1a0);
      ahb(1'b1, REG_CMD, 32'h503);
      repeat (4) @(posedge clk);
      chk("erase strobes", 32'h1, erase_cnt);
      chk("erase page", 32'hd, {27'h0, fl_page});
      reset_during_halt();
      give_verdict();
   end

   // Watchdog well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule // tb_fuse_lock_readout_protection
`default_nettype wire
